// >>> blfs_host_model.sv
// Host side model: drives enable, brightness and serial bus activity.
// Assumes the sequencer clock; all changes land by NBA at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module blfs_host_model (
    input  wire logic        ref_clk_in,
    input  wire logic        config_write_en_in,
    output var  logic        enable_out,
    output var  logic [15:0] brightness_out,
    output var  logic        bus_busy_out
);
    initial begin
        enable_out = 1'b0;
        brightness_out = 16'h0000;
        bus_busy_out = 1'b0;
    end
    // Enable low is the only way out of latch
    task automatic set_en(input logic v);
        @(posedge ref_clk_in);
        enable_out <= v;
    endtask
    // Writes once the device accepts configuration, or after waiting 200 cycles without it
    task automatic set_brt(input logic [15:0] v);
        int n;
        n = 0;
        while (config_write_en_in !== 1'b1 && n < 200) begin
            @(posedge ref_clk_in);
            n++;
        end
        @(posedge ref_clk_in);
        brightness_out <= v;
    endtask
    // Command that never sees its stop
    task automatic hold_bus(input int cyc);
        @(posedge ref_clk_in);
        bus_busy_out <= 1'b1;
        repeat (cyc) @(posedge ref_clk_in);
        bus_busy_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> blfs_sequencer.sv
// Functional state machine and fault manager of the backlight driver.
// Assumes analog comparators and enable arrive as async pins; config inputs share the clock.
`timescale 1ns/1ps
`default_nettype none

module blfs_sequencer import blfs_pkg::*; #(
    parameter int unsigned SOFT_CYCLES  = SOFT_CYC,
    parameter int unsigned BOOST_CYCLES = BOOST_CYC,
    parameter int unsigned RECOV_CYCLES = RECOV_CYC,
    parameter int unsigned DISCH_CYCLES = DISCH_CYC,
    parameter int unsigned SHORT_CYCLES = SHORT_CYC,
    parameter int unsigned BUS_CYCLES   = BUS_CYC
) (
    input  wire logic            ref_clk_in,
    input  wire logic            rstn_in,
    input  wire logic            enable_in,
    input  wire logic            current_set_low_in,
    input  wire logic            overtemp_in,
    input  wire logic            boost_at_max_in,
    input  wire logic            bus_busy_in,
    input  wire blfs_sense_type  sense_in,
    input  wire logic            init_done_in,
    input  wire logic [CH-1:0]   string_used_in,
    input  wire logic [15:0]     brightness_in,
    input  wire logic [11:0]     sink_current_cfg_in,
    input  wire blfs_status_type status_clear_in,
    output var  blfs_state_type  state_out,
    output var  logic            regulator_en_out,
    output var  logic            trim_load_out,
    output var  logic            config_write_en_out,
    output var  logic            pl_switch_en_out,
    output var  logic            boost_en_out,
    output var  logic            boost_ramp_out,
    output var  logic            discharge_out,
    output var  logic            supply_det_en_out,
    output var  logic            boost_det_en_out,
    output var  logic            led_det_en_out,
    output var  logic            test_current_out,
    output var  logic [CH-1:0]   led_en_out,
    output var  logic [CH-1:0]   string_disabled_out,
    output var  logic [11:0]     sink_current_field_out,
    output var  logic            sink_current_force_out,
    output var  logic            bus_reset_out,
    output var  blfs_status_type status_out,
    output var  logic            int_out
);
    localparam int unsigned SW = 5 + 4 * CH;

    // Pin synchronisers: change accepted when second and third stages agree
    logic [SW-1:0] pin_raw;
    logic [SW-1:0] s1_reg;
    logic [SW-1:0] s2_reg;
    logic [SW-1:0] s3_reg;
    logic [SW-1:0] pin_reg;
    logic [SW-1:0] agree;

    assign pin_raw = {enable_in, current_set_low_in, overtemp_in, boost_at_max_in,
                      bus_busy_in, sense_in};
    assign agree   = ~(s2_reg ^ s3_reg);

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            pin_reg <= '0;
        end else begin
            s1_reg  <= pin_raw;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= (pin_reg & ~agree) | (s3_reg & agree);
        end
    end

    logic           en_f;
    logic           cs_f;
    logic           ot_f;
    logic           bmax_f;
    logic           busy_f;
    blfs_sense_type sns;

    assign en_f   = pin_reg[SW-1];
    assign cs_f   = pin_reg[SW-2];
    assign ot_f   = pin_reg[SW-3];
    assign bmax_f = pin_reg[SW-4];
    assign busy_f = pin_reg[SW-5];
    assign sns    = blfs_sense_type'(pin_reg[4*CH-1:0]);

    blfs_state_type state_reg;
    blfs_state_type state_next;
    logic [31:0]    dwell_cnt_reg;
    logic [31:0]    dwell_lim;
    logic           dwell_done;
    logic [CH-1:0]  disabled_reg;
    logic [CH-1:0]  disabled_next;
    logic [CH-1:0]  open_hit;
    logic [CH-1:0]  short_hit;
    logic           brt_nz;
    logic           gnd_soft_hit;
    logic           gnd_run_hit;
    logic           invalid_hit;
    logic           all_dis;
    logic           bus_hit;
    logic           bus_hit_q_reg;
    logic           running;

    assign brt_nz  = |brightness_in;
    assign running = (state_reg == ST_BOOST) || (state_reg == ST_NORMAL);

    // Dwell limit per state
    always_comb begin
        case (state_reg)
            ST_PL_SOFT:  dwell_lim = 32'(SOFT_CYCLES);
            ST_BOOST:    dwell_lim = 32'(BOOST_CYCLES);
            ST_RECOVERY: dwell_lim = 32'(RECOV_CYCLES);
            ST_SHUTDOWN: dwell_lim = 32'(DISCH_CYCLES);
            default:     dwell_lim = 32'h0000_0001;
        endcase
    end
    assign dwell_done = dwell_cnt_reg >= (dwell_lim - 32'h0000_0001);

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dwell_cnt_reg <= 32'h0000_0000;
        end else if (state_next != state_reg) begin
            dwell_cnt_reg <= 32'h0000_0000;
        end else if (!dwell_done) begin
            dwell_cnt_reg <= dwell_cnt_reg + 32'h0000_0001;
        end
    end

    // String fault detection
    assign open_hit = (state_reg == ST_NORMAL) ?
                      (sns.headroom_low & {CH{bmax_f}} & led_en_out) : '0;

    genvar gi;
    generate
        for (gi = 0; gi < CH; gi++) begin : g_short
            blfs_qual #(.LIMIT(SHORT_CYCLES)) u_short_qual (
                .ref_clk_in (ref_clk_in),
                .rstn_in    (rstn_in),
                .cond_in    ((state_reg == ST_NORMAL) && led_en_out[gi] &&
                             sns.above_short[gi] &&
                             (|(led_en_out & ~sns.above_short))),
                .hit_out    (short_hit[gi])
            );
        end
    endgenerate

    assign disabled_next = disabled_reg | open_hit | short_hit;
    assign all_dis       = (|string_used_in) &&
                           ((string_used_in & ~disabled_reg) == '0);
    assign gnd_soft_hit  = (state_reg == ST_PL_SOFT) && dwell_done &&
                           (|(string_used_in & sns.below_headroom));
    assign gnd_run_hit   = running &&
                           (|(string_used_in & ~led_en_out & sns.below_gnd));
    assign invalid_hit   = (state_reg == ST_PL_SOFT) && dwell_done &&
                           (|(~string_used_in & ~sns.below_gnd));

    blfs_qual #(.LIMIT(BUS_CYCLES)) u_bus_qual (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .cond_in    (busy_f),
        .hit_out    (bus_hit)
    );

    // Next state
    always_comb begin
        state_next = state_reg;
        if (!en_f && (state_reg != ST_INIT) && (state_reg != ST_SHUTDOWN) &&
            (state_reg != ST_OFF)) begin
            state_next = ST_SHUTDOWN;
        end else begin
            case (state_reg)
                ST_INIT: begin
                    if (init_done_in) begin
                        state_next = en_f ? ST_STANDBY : ST_OFF;
                    end
                end
                ST_STANDBY: begin
                    if (!ot_f) begin
                        state_next = ST_PL_SOFT;
                    end
                end
                ST_PL_SOFT: begin
                    if (ot_f) begin
                        state_next = ST_STANDBY;
                    end else if (gnd_soft_hit) begin
                        state_next = ST_RECOVERY;
                    end else if (dwell_done) begin
                        state_next = ST_BOOST;
                    end
                end
                ST_BOOST, ST_NORMAL: begin
                    if (ot_f) begin
                        state_next = ST_STANDBY;
                    end else if (gnd_run_hit) begin
                        state_next = ST_RECOVERY;
                    end else if (all_dis) begin
                        state_next = ST_LATCH;
                    end else if ((state_reg == ST_BOOST) && dwell_done) begin
                        state_next = ST_NORMAL;
                    end
                end
                ST_RECOVERY: begin
                    if (dwell_done && brt_nz) begin
                        state_next = ST_STANDBY;
                    end
                end
                ST_LATCH: begin
                    state_next = ST_LATCH;
                end
                ST_SHUTDOWN: begin
                    if (dwell_done) begin
                        state_next = ST_OFF;
                    end
                end
                ST_OFF: begin
                    if (en_f) begin
                        state_next = ST_INIT;
                    end
                end
                default: begin
                    state_next = ST_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= ST_INIT;
        end else begin
            state_reg <= state_next;
        end
    end
    assign state_out = state_reg;

    // Disabled strings survive until reset only
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            disabled_reg <= STR_RESET;
        end else begin
            disabled_reg <= disabled_next;
        end
    end
    assign string_disabled_out = disabled_reg;

    // Power path and detection enables, registered from next state
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            regulator_en_out    <= 1'b0;
            trim_load_out       <= 1'b0;
            config_write_en_out <= 1'b0;
            pl_switch_en_out    <= 1'b0;
            boost_en_out        <= 1'b0;
            boost_ramp_out      <= 1'b0;
            discharge_out       <= 1'b0;
            supply_det_en_out   <= 1'b0;
            boost_det_en_out    <= 1'b0;
            led_det_en_out      <= 1'b0;
            test_current_out    <= 1'b0;
            led_en_out          <= '0;
        end else begin
            regulator_en_out    <= (state_next != ST_OFF);
            trim_load_out       <= (state_next == ST_INIT);
            config_write_en_out <= (state_next != ST_INIT) && (state_next != ST_SHUTDOWN) &&
                                   (state_next != ST_OFF);
            pl_switch_en_out    <= (state_next == ST_PL_SOFT) || (state_next == ST_BOOST) ||
                                   (state_next == ST_NORMAL);
            boost_en_out        <= (state_next == ST_BOOST) || (state_next == ST_NORMAL);
            boost_ramp_out      <= (state_next == ST_BOOST);
            discharge_out       <= (state_next == ST_SHUTDOWN);
            supply_det_en_out   <= (state_next == ST_PL_SOFT) || (state_next == ST_BOOST) ||
                                   (state_next == ST_NORMAL);
            boost_det_en_out    <= (state_next == ST_BOOST) || (state_next == ST_NORMAL);
            led_det_en_out      <= (state_next == ST_NORMAL);
            test_current_out    <= (state_next == ST_PL_SOFT) || (state_next == ST_BOOST) ||
                                   (state_next == ST_NORMAL);
            led_en_out          <= ((state_next == ST_NORMAL) && brt_nz) ?
                                   (string_used_in & ~disabled_next) : '0;
        end
    end

    // Current field override
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sink_current_field_out <= SINK_RESET;
            sink_current_force_out <= 1'b0;
        end else begin
            sink_current_field_out <= cs_f ? SINK_FORCED : sink_current_cfg_in;
            sink_current_force_out <= cs_f;
        end
    end

    // Bus timeout pulse resets serial logic
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_hit_q_reg <= 1'b0;
            bus_reset_out <= 1'b0;
        end else begin
            bus_hit_q_reg <= bus_hit;
            bus_reset_out <= bus_hit && !bus_hit_q_reg;
        end
    end

    // Sticky status; a set in the clearing cycle wins
    blfs_status_type status_set;
    blfs_status_type status_next;

    always_comb begin
        status_set                        = '0;
        status_set.current_set_fault_flag = cs_f;
        status_set.overtemp_flag          = ot_f;
        status_set.open_string_flag       = |open_hit;
        status_set.string_short_flag      = |short_hit;
        status_set.ground_short_flag      = gnd_soft_hit || gnd_run_hit;
        status_set.invalid_string_flag    = invalid_hit;
        status_set.bus_error_flag         = bus_hit && !bus_hit_q_reg;
        status_next = (status_out & ~status_clear_in) | status_set;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_out <= '0;
            int_out    <= 1'b0;
        end else begin
            status_out <= status_next;
            int_out    <= |status_next;
        end
    end

    // Checks
    sequence seq_enable_drop;
        $fell(en_f) && (state_reg != ST_INIT) && (state_reg != ST_OFF) &&
        (state_reg != ST_SHUTDOWN);
    endsequence

    sequence seq_all_off;
        discharge_out && !boost_en_out && !pl_switch_en_out && (led_en_out == '0);
    endsequence

    a_current_set_pin_force: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        cs_f |=> (sink_current_field_out == SINK_FORCED) && status_out.current_set_fault_flag)
        else $error("current-set fault did not force the field");

    a_tsd_standby: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (ot_f && en_f && (running || (state_reg == ST_PL_SOFT))) |=> (state_reg == ST_STANDBY)
        ##1 ((state_reg == ST_STANDBY) || !$past(ot_f) || !$past(en_f)))
        else $error("overtemperature did not hold standby");

    a_open_disable: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (open_hit != '0) |=> ((string_disabled_out & $past(open_hit)) == $past(open_hit)) &&
        status_out.open_string_flag ##1 (led_en_out & $past(open_hit, 2)) == '0)
        else $error("open string not disabled");

    a_short_flag: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (short_hit != '0) |=> status_out.string_short_flag && int_out)
        else $error("string short not flagged");

    a_gnd_recover: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (gnd_run_hit && en_f && !ot_f) |=> (state_reg == ST_RECOVERY) &&
        !boost_en_out && !pl_switch_en_out)
        else $error("ground short did not enter recovery");

    a_bus_reset: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        $rose(bus_hit) |=> bus_reset_out && status_out.bus_error_flag ##1 !bus_reset_out)
        else $error("bus timeout pulse wrong");

    a_shutdown_off: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        seq_enable_drop |=> seq_all_off)
        else $error("enable drop did not shut down outputs");

    a_soft_len: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        ($past(state_reg) == ST_PL_SOFT) && (state_reg == ST_BOOST) |->
        ($past(dwell_cnt_reg) == 32'(SOFT_CYCLES - 1)))
        else $error("soft start length wrong");

    a_recov_len: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        ($past(state_reg) == ST_RECOVERY) && (state_reg == ST_STANDBY) |->
        ($past(dwell_cnt_reg) >= 32'(RECOV_CYCLES - 1)) && $past(brt_nz))
        else $error("recovery left early");

    a_latch_hold: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (state_reg == ST_LATCH) && en_f |=> (state_reg == ST_LATCH) && (led_en_out == '0))
        else $error("latched fault left while enabled");

    a_int_any: assert property (@(posedge ref_clk_in) disable iff (!rstn_in)
        (status_set != '0) |=> int_out &&
        ((status_out & $past(status_set)) == $past(status_set)))
        else $error("interrupt missing for flagged fault");
endmodule

`default_nettype wire

// >>> blfs_sequencer_tb.sv
// Self-checking bench of the backlight sequencer with shortened dwell counts.
// Assumes blfs_pkg, blfs_sequencer and blfs_host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module blfs_sequencer_tb import blfs_pkg::*;;
    localparam int SOFT = 20, BOOST = 30, RECOV = 40, DISCH = 50, SHORT = 10, BUS = 60;
    logic clk = 1'b0, rstn = 1'b0, idone = 1'b0, csl = 1'b0, ot = 1'b0, bmax = 1'b0;
    logic [3:0] used = 4'h7, hl = 4'h0, ab = 4'h0, bh = 4'h0, bg = 4'h0, len, sdis;
    logic [11:0] cfg = 12'h123, fld;
    blfs_status_type clr = '0, sts;
    blfs_state_type st;
    logic en, bbusy, rg, tr, cw, pl, bs, rp, ds, sd, bd, ld, tc, frc, brst, irq;
    logic [15:0] brt;
    int n_mismatch = 0, n_compared = 0, cyc = 0, nrst = 0;
    always #12.5 clk = ~clk;
    blfs_host_model host (.ref_clk_in(clk), .config_write_en_in(cw), .enable_out(en),
        .brightness_out(brt), .bus_busy_out(bbusy));
    blfs_sequencer #(.SOFT_CYCLES(SOFT), .BOOST_CYCLES(BOOST), .RECOV_CYCLES(RECOV),
        .DISCH_CYCLES(DISCH), .SHORT_CYCLES(SHORT), .BUS_CYCLES(BUS)) DUT (
        .ref_clk_in(clk), .rstn_in(rstn), .enable_in(en), .current_set_low_in(csl),
        .overtemp_in(ot), .boost_at_max_in(bmax), .bus_busy_in(bbusy),
        .sense_in({hl, ab, bh, bg}), .init_done_in(idone), .string_used_in(used),
        .brightness_in(brt), .sink_current_cfg_in(cfg), .status_clear_in(clr),
        .state_out(st), .regulator_en_out(rg), .trim_load_out(tr), .config_write_en_out(cw),
        .pl_switch_en_out(pl), .boost_en_out(bs), .boost_ramp_out(rp), .discharge_out(ds),
        .supply_det_en_out(sd), .boost_det_en_out(bd), .led_det_en_out(ld),
        .test_current_out(tc), .led_en_out(len), .string_disabled_out(sdis),
        .sink_current_field_out(fld), .sink_current_force_out(frc), .bus_reset_out(brst),
        .status_out(sts), .int_out(irq));
    task automatic give_verdict;
        if (n_mismatch == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (brst === 1'b1)
            nrst++;
        if (cyc > 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Waits for a state under a bound, then compares it
    task automatic ws(input blfs_state_type s, input int max);
        int n;
        n = 0;
        while (st !== s && n < max) begin
            tick(1);
            n++;
        end
        cmp("state_out", 16'(s), 16'(st));
    endtask
    task automatic clr_all;
        @(posedge clk);
        clr <= 7'h7F;
        @(posedge clk);
        clr <= 7'h00;
        tick(2);
        cmp("status_out", 16'h0000, 16'(sts));
        cmp("int_out", 16'h0000, 16'(irq));
    endtask
    initial begin
        host.set_en(1'b1);
        tick(1);
        cmp("reset outputs", 16'h0000, 16'({st, rg, tr, len}));
        @(posedge clk);
        rstn <= 1'b1;
        tick(2);
        cmp("init outputs", 16'h0003, 16'({rg, tr}));
        @(posedge clk);
        idone <= 1'b1;
        ws(ST_STANDBY, 10);
        cmp("config_write_en", 16'h0001, 16'(cw));
        ws(ST_PL_SOFT, 3);
        cmp("soft outputs", 16'h0007, 16'({pl, sd, tc}));
        tick(SOFT - 3);
        cmp("state_out", 16'(ST_PL_SOFT), 16'(st));
        ws(ST_BOOST, 6);
        cmp("boost outputs", 16'h0007, 16'({bs, rp, bd}));
        cmp("status_out", 16'h0005, 16'({sts, irq}));
        tick(BOOST - 3);
        cmp("state_out", 16'(ST_BOOST), 16'(st));
        ws(ST_NORMAL, 6);
        cmp("led_en dark", 16'h0010, 16'({ld, len}));
        host.set_brt(16'h8000);
        tick(2);
        cmp("led_en lit", 16'h0017, 16'({ld, len}));
        clr_all();
        @(posedge clk);
        csl <= 1'b1;
        tick(8);
        cmp("current fault", 16'h13FF, 16'({frc, fld}));
        cmp("status_out", 16'h0081, 16'({sts, irq}));
        ws(ST_NORMAL, 1);
        @(posedge clk);
        csl <= 1'b0;
        tick(8);
        cmp("sink_current_field", 16'h0123, 16'(fld));
        clr_all();
        host.hold_bus(BUS + 10);
        tick(2);
        cmp("status_out", 16'h0003, 16'({sts, irq}));
        cmp("bus_reset pulses", 16'h0001, 16'(nrst));
        ws(ST_NORMAL, 1);
        clr_all();
        @(posedge clk);
        hl <= 4'h1;
        bmax <= 1'b1;
        tick(8);
        cmp("status_out", 16'h0021, 16'({sts, irq}));
        cmp("disabled, led_en", 16'h0016, 16'({sdis, len}));
        @(posedge clk);
        hl <= 4'h0;
        bmax <= 1'b0;
        ab <= 4'h2;
        tick(SHORT - 4);
        cmp("short early", 16'h0000, 16'(sts[3]));
        tick(12);
        cmp("status_out", 16'h0031, 16'({sts, irq}));
        cmp("string_disabled", 16'h0003, 16'(sdis));
        @(posedge clk);
        ab <= 4'h0;
        clr_all();
        host.set_brt(16'h0000);
        tick(2);
        @(posedge clk);
        bg <= 4'h4;
        ws(ST_RECOVERY, 10);
        cmp("recovery outputs", 16'h0000, 16'({pl, bs, len}));
        cmp("ground flag", 16'h0001, 16'(sts[2]));
        @(posedge clk);
        bg <= 4'h0;
        host.set_brt(16'h8000);
        tick(RECOV - 10);
        cmp("state_out", 16'(ST_RECOVERY), 16'(st));
        ws(ST_STANDBY, 20);
        ws(ST_PL_SOFT, 5);
        @(posedge clk);
        ot <= 1'b1;
        ws(ST_STANDBY, 8);
        cmp("overtemp flag", 16'h0003, 16'({sts[5], irq}));
        tick(10);
        cmp("state_out", 16'(ST_STANDBY), 16'(st));
        @(posedge clk);
        ot <= 1'b0;
        ws(ST_PL_SOFT, 8);
        clr_all();
        @(posedge clk);
        bh <= 4'h1;
        ws(ST_RECOVERY, SOFT);
        cmp("ground flag", 16'h0001, 16'(sts[2]));
        @(posedge clk);
        bh <= 4'h0;
        ws(ST_STANDBY, RECOV + 5);
        ws(ST_NORMAL, SOFT + BOOST + 10);
        @(posedge clk);
        hl <= 4'h4;
        bmax <= 1'b1;
        ws(ST_LATCH, 12);
        tick(10);
        cmp("state_out", 16'(ST_LATCH), 16'(st));
        host.set_en(1'b0);
        ws(ST_SHUTDOWN, 8);
        cmp("shutdown outputs", 16'h0040, 16'({ds, pl, bs, len}));
        tick(DISCH - 3);
        cmp("state_out", 16'(ST_SHUTDOWN), 16'(st));
        ws(ST_OFF, 8);
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> blfs_timer.sv
// Shared constants and types of the backlight sequencer, plus the persistence qualifier.
// Assumes a single 40 MHz clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none

package blfs_pkg;
    // Channel count and clock rate
    localparam int unsigned CH       = 4;
    localparam int unsigned CLK_HZ   = 40_000_000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

    // Dwell and qualification times in ms
    localparam int unsigned SOFT_MS  = 25;
    localparam int unsigned BOOST_MS = 50;
    localparam int unsigned RECOV_MS = 100;
    localparam int unsigned DISCH_MS = 400;
    localparam int unsigned SHORT_MS = 5;
    localparam int unsigned BUS_MS   = 500;

    // Derived cycle counts
    localparam int unsigned SOFT_CYC  = SOFT_MS * CYC_PER_MS;
    localparam int unsigned BOOST_CYC = BOOST_MS * CYC_PER_MS;
    localparam int unsigned RECOV_CYC = RECOV_MS * CYC_PER_MS;
    localparam int unsigned DISCH_CYC = DISCH_MS * CYC_PER_MS;
    localparam int unsigned SHORT_CYC = SHORT_MS * CYC_PER_MS;
    localparam int unsigned BUS_CYC   = BUS_MS * CYC_PER_MS;

    // Forced sink current under a current-set fault
    localparam logic [11:0] SINK_FORCED = 12'h3FF;
    localparam logic [11:0] SINK_RESET  = 12'h000;
    localparam logic [3:0]  STR_RESET   = 4'h0;

    typedef enum logic [3:0] {
        ST_INIT     = 4'h0,
        ST_STANDBY  = 4'h1,
        ST_PL_SOFT  = 4'h2,
        ST_BOOST    = 4'h3,
        ST_NORMAL   = 4'h4,
        ST_RECOVERY = 4'h5,
        ST_LATCH    = 4'h6,
        ST_SHUTDOWN = 4'h7,
        ST_OFF      = 4'h8
    } blfs_state_type;

    typedef struct packed {
        logic current_set_fault_flag;
        logic overtemp_flag;
        logic open_string_flag;
        logic string_short_flag;
        logic ground_short_flag;
        logic invalid_string_flag;
        logic bus_error_flag;
    } blfs_status_type;

    typedef struct packed {
        logic [CH-1:0] headroom_low;
        logic [CH-1:0] above_short;
        logic [CH-1:0] below_headroom;
        logic [CH-1:0] below_gnd;
    } blfs_sense_type;
endpackage

// Raises hit_out once cond_in has held for LIMIT cycles; drops with cond_in
module blfs_qual #(
    parameter int unsigned LIMIT = 16
) (
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    input  wire logic cond_in,
    output var  logic hit_out
);
    logic [31:0] cnt_reg;

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cnt_reg <= 32'h0000_0000;
        end else if (!cond_in) begin
            cnt_reg <= 32'h0000_0000;
        end else if (cnt_reg < 32'(LIMIT)) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end

    assign hit_out = cond_in && (cnt_reg >= 32'(LIMIT - 1));
endmodule

`default_nettype wire
